// file: design/egrs_divider.v
// sequential signed divider, truncating, remainder takes the dividend's sign
module egrs_divider (
    // clock and reset
    input wire clk,
    input wire rst,
    // request
    input wire start,
    input wire signed [63:0] dividend,
    input wire [31:0] divisor,
    // answer
    output reg busy,
    output reg done,
    output reg signed [63:0] quotient,
    output reg signed [31:0] remainder
);

    reg [63:0] quo_q;
    reg [32:0] rem_q;
    reg [32:0] div_q;
    reg neg_q;
    reg [6:0] cnt_q;
    wire [32:0] remShift;
    wire remFits;

    assign remShift = {rem_q[31:0], quo_q[63]};
    assign remFits = (remShift >= div_q);

    always @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            quo_q <= 64'h0000_0000_0000_0000;
            rem_q <= 33'h0_0000_0000;
            div_q <= 33'h0_0000_0001;
            neg_q <= 1'b0;
            cnt_q <= 7'h00;
            quotient <= 64'h0000_0000_0000_0000;
            remainder <= 32'h0000_0000;
        end else begin
            done <= 1'b0;
            if (!busy && start) begin
                busy <= 1'b1;
                neg_q <= dividend[63];
                quo_q <= dividend[63] ? -dividend : dividend;
                rem_q <= 33'h0_0000_0000;
                div_q <= {1'b0, divisor};
                cnt_q <= 7'h40;
            end else if (busy) begin
                // restoring step on magnitudes, signs applied at the end
                quo_q <= {quo_q[62:0], remFits};
                rem_q <= remFits ? remShift - div_q : remShift;
                cnt_q <= cnt_q - 7'h01;
                if (cnt_q == 7'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    if (neg_q) begin
                        quotient <= -$signed({quo_q[62:0], remFits});
                        remainder <= -$signed(remFits ? remShift[31:0] - div_q[31:0]
                                                      : remShift[31:0]);
                    end else begin
                        quotient <= $signed({quo_q[62:0], remFits});
                        remainder <= $signed(remFits ? remShift[31:0] - div_q[31:0]
                                                     : remShift[31:0]);
                    end
                end
            end
        end
    end

endmodule // egrs_divider

// file: design/egrs_gear_scaler.v
// electronic gear ratio scaler: ratio registers, scaling, follow limitation, lag
//
// How it works
// - motor increments are reference increments times numerator over denominator
// - preset selector takes 0..11, resets to 0; 0 picks user ratio
// - presets 1..11 mean 200..16384 reference increments per motor revolution
// - negative numerator reverses motor direction against the reference
// - new user ratio takes effect only on a numerator write
// - numerator is signed 32-bit full range, reset value 1
// - denominator is 1..2147483647, reset value 1
// - process data: denominator 16-bit in word 2, numerator 32-bit in words 3,4
// - limitation enable: 0 inactive, 1 active, reset 0
// - with limitation on, speed and acceleration are clamped to ceilings
// - readable lag is reference position minus effective position
// - presets scale to 131072 motor increments per revolution
// - lag beyond 400 revolutions stops operation and raises a fault
`include "egrs_regs.vh"

module egrs_gear_scaler #(
    parameter TICK_CYCLES = `EGRS_TICK_CYCLES,
    parameter REF_W = 16
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // reference increments from the external controller
    input wire refValid,
    input wire signed [REF_W-1:0] refInc,
    // parameter access
    input wire paramWrEn,
    input wire paramRdEn,
    input wire [15:0] paramAddr,
    input wire [31:0] paramWrData,
    output reg [31:0] paramRdData_q,
    output reg paramRdValid_q,
    // cyclic process data
    input wire pzdValid,
    input wire [15:0] pzdWord2,
    input wire [15:0] pzdWord3,
    input wire [15:0] pzdWord4,
    // position and status
    output reg signed [31:0] effPos_q,
    output reg signed [31:0] lag_q,
    output reg fault_q
);

    // ********************************
    // helpers
    // ********************************
    function [31:0] presetRefsPerRev;
        input [3:0] code;
        begin
            case (code)
                4'h1: presetRefsPerRev = 32'h0000_00c8;
                4'h2: presetRefsPerRev = 32'h0000_0190;
                4'h3: presetRefsPerRev = 32'h0000_01f4;
                4'h4: presetRefsPerRev = 32'h0000_03e8;
                4'h5: presetRefsPerRev = 32'h0000_07d0;
                4'h6: presetRefsPerRev = 32'h0000_0fa0;
                4'h7: presetRefsPerRev = 32'h0000_1388;
                4'h8: presetRefsPerRev = 32'h0000_2710;
                4'h9: presetRefsPerRev = 32'h0000_1000;
                4'ha: presetRefsPerRev = 32'h0000_2000;
                4'hb: presetRefsPerRev = 32'h0000_4000;
                default: presetRefsPerRev = 32'h0000_0001;
            endcase
        end
    endfunction

    function signed [31:0] clampSym;
        input signed [31:0] v;
        input [31:0] lim;
        begin
            if (v > $signed(lim))
                clampSym = $signed(lim);
            else if (v < -$signed(lim))
                clampSym = -$signed(lim);
            else
                clampSym = v;
        end
    endfunction

    // ********************************
    // parameter registers
    // ********************************
    reg signed [31:0] numReg_q;
    reg signed [31:0] denReg_q;
    reg signed [31:0] actNum_q;
    reg signed [31:0] actDen_q;
    reg [3:0] preset_q;
    reg limitEn_q;
    reg [31:0] speedCeil_q;
    reg [31:0] accelCeil_q;
    reg ratioChanged;

    wire wrDen = paramWrEn && (paramAddr == `EGRS_ADDR_DENOM);
    wire wrNum = paramWrEn && (paramAddr == `EGRS_ADDR_NUM);
    wire denOk = !paramWrData[31] && (paramWrData != 32'h0000_0000);
    wire pzdDenOk = (pzdWord2 != 16'h0000);
    wire signed [31:0] newDen = wrDen && denOk ? $signed(paramWrData) : denReg_q;

    always @(posedge clk) begin
        if (rst) begin
            numReg_q <= `EGRS_RST_NUM;
            denReg_q <= `EGRS_RST_DENOM;
            actNum_q <= `EGRS_RST_NUM;
            actDen_q <= `EGRS_RST_DENOM;
            preset_q <= `EGRS_RST_PRESET;
            limitEn_q <= 1'b0;
            speedCeil_q <= `EGRS_RST_SPEED_CEIL;
            accelCeil_q <= `EGRS_RST_ACCEL_CEIL;
            ratioChanged <= 1'b0;
        end else begin
            ratioChanged <= 1'b0;
            if (pzdValid) begin
                // process data carries both halves, numerator arrival applies it
                numReg_q <= {pzdWord3, pzdWord4};
                actNum_q <= {pzdWord3, pzdWord4};
                if (pzdDenOk) begin
                    denReg_q <= {16'h0000, pzdWord2};
                    actDen_q <= {16'h0000, pzdWord2};
                end else begin
                    actDen_q <= denReg_q;
                end
                ratioChanged <= 1'b1;
            end else begin
                if (wrDen && denOk)
                    denReg_q <= paramWrData; // out-of-range writes are ignored
                if (wrNum) begin
                    numReg_q <= paramWrData;
                    actNum_q <= paramWrData;
                    actDen_q <= newDen;
                    ratioChanged <= 1'b1;
                end
            end
            if (paramWrEn && paramAddr == `EGRS_ADDR_PRESET &&
                    paramWrData[31:4] == 28'h000_0000 &&
                    paramWrData[3:0] <= `EGRS_PRESET_MAX) begin
                preset_q <= paramWrData[3:0];
                ratioChanged <= 1'b1;
            end
            if (paramWrEn && paramAddr == `EGRS_ADDR_LIMIT_EN &&
                    paramWrData[31:1] == 31'h0000_0000)
                limitEn_q <= paramWrData[0];
            if (paramWrEn && paramAddr == `EGRS_ADDR_SPEED_CEIL)
                speedCeil_q <= paramWrData;
            if (paramWrEn && paramAddr == `EGRS_ADDR_ACCEL_CEIL)
                accelCeil_q <= paramWrData;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            paramRdData_q <= 32'h0000_0000;
            paramRdValid_q <= 1'b0;
        end else begin
            paramRdValid_q <= paramRdEn;
            case (paramAddr)
                `EGRS_ADDR_DENOM: paramRdData_q <= denReg_q;
                `EGRS_ADDR_NUM: paramRdData_q <= numReg_q;
                `EGRS_ADDR_PRESET: paramRdData_q <= {28'h000_0000, preset_q};
                `EGRS_ADDR_LIMIT_EN: paramRdData_q <= {31'h0000_0000, limitEn_q};
                `EGRS_ADDR_SPEED_CEIL: paramRdData_q <= speedCeil_q;
                `EGRS_ADDR_ACCEL_CEIL: paramRdData_q <= accelCeil_q;
                `EGRS_ADDR_LAG: paramRdData_q <= lag_q;
                default: paramRdData_q <= 32'h0000_0000;
            endcase
        end
    end

    // ********************************
    // scaling
    // ********************************
    // preset picks 131072 over refs-per-rev, code 0 picks the user pair
    wire signed [31:0] useNum = (preset_q == 4'h0) ? actNum_q
                                                   : `EGRS_MOTOR_INC_PER_REV;
    wire signed [31:0] useDen = (preset_q == 4'h0) ? actDen_q
                                                   : presetRefsPerRev(preset_q);

    // increments that arrive while the divider runs pile up here, none are lost until a fault is raised
    reg signed [23:0] pendAcc_q;
    reg signed [31:0] carry_q;
    reg signed [31:0] refPos_q;
    wire divBusy;
    wire divDone;
    wire signed [63:0] divQuo;
    wire signed [31:0] divRem;
    wire launch = !divBusy && !divDone && (pendAcc_q != 24'sh00_0000) && !fault_q;
    wire signed [23:0] refExt = {{(24-REF_W){refInc[REF_W-1]}}, refInc};
    wire signed [23:0] addIn = (refValid && !fault_q) ? refExt : 24'sh00_0000;
    wire signed [63:0] product = pendAcc_q * useNum;
    wire signed [63:0] dividend = product + {{32{carry_q[31]}}, carry_q};

    egrs_divider u_div (
        .clk(clk),
        .rst(rst),
        .start(launch),
        .dividend(dividend),
        .divisor(useDen),
        .busy(divBusy),
        .done(divDone),
        .quotient(divQuo),
        .remainder(divRem)
    );

    always @(posedge clk) begin
        if (rst) begin
            pendAcc_q <= 24'sh00_0000;
            carry_q <= 32'sh0000_0000;
            refPos_q <= 32'sh0000_0000;
        end else begin
            pendAcc_q <= (launch ? 24'sh00_0000 : pendAcc_q) + addIn;
            if (divDone) begin
                refPos_q <= refPos_q + divQuo[31:0];
                carry_q <= divRem;
            end
            // a remainder left from the old ratio means nothing under a new one
            if (ratioChanged)
                carry_q <= 32'sh0000_0000;
        end
    end

    // ********************************
    // follow limitation and lag
    // ********************************
    reg [15:0] tickCnt_q;
    reg signed [31:0] vel_q;
    wire tick = (tickCnt_q == TICK_CYCLES[15:0] - 16'h0001);
    wire signed [31:0] posErr = refPos_q - effPos_q;
    wire signed [31:0] velTarget = clampSym(posErr, speedCeil_q);
    wire signed [31:0] velNext = vel_q + clampSym(velTarget - vel_q, accelCeil_q);
    wire [31:0] lagMag = lag_q[31] ? -lag_q : lag_q;
    wire [31:0] lagLimit = `EGRS_LAG_LIMIT_REVS * `EGRS_MOTOR_INC_PER_REV;

    always @(posedge clk) begin
        if (rst) begin
            tickCnt_q <= 16'h0000;
            vel_q <= 32'sh0000_0000;
            effPos_q <= 32'sh0000_0000;
            lag_q <= 32'sh0000_0000;
            fault_q <= 1'b0;
        end else begin
            tickCnt_q <= tick ? 16'h0000 : tickCnt_q + 16'h0001;
            lag_q <= posErr;
            if (lagMag > lagLimit)
                fault_q <= 1'b1;
            if (fault_q || lagMag > lagLimit) begin
                // stopped: hold position until reset
                vel_q <= 32'sh0000_0000;
            end else if (!limitEn_q) begin
                // source is trusted to be followable, so track directly
                effPos_q <= refPos_q;
                vel_q <= 32'sh0000_0000;
            end else if (tick) begin
                vel_q <= velNext;
                effPos_q <= effPos_q + velNext;
            end
        end
    end

endmodule // egrs_gear_scaler

// file: design/egrs_regs.vh
// register offsets, reset values and timing constants of the gear ratio scaler
`ifndef EGRS_REGS_VH
`define EGRS_REGS_VH

// ********************************
// parameter addresses
// ********************************
`define EGRS_ADDR_DENOM 16'h2606
`define EGRS_ADDR_NUM 16'h2608
`define EGRS_ADDR_PRESET 16'h260c
`define EGRS_ADDR_LIMIT_EN 16'h2610
`define EGRS_ADDR_SPEED_CEIL 16'h2612
`define EGRS_ADDR_ACCEL_CEIL 16'h2614
`define EGRS_ADDR_LAG 16'h1e2c

// ********************************
// reset values and ranges
// ********************************
`define EGRS_RST_DENOM 32'h0000_0001
`define EGRS_RST_NUM 32'h0000_0001
`define EGRS_RST_PRESET 4'h0
`define EGRS_PRESET_MAX 4'hb
`define EGRS_RST_SPEED_CEIL 32'h0000_0bb8
`define EGRS_RST_ACCEL_CEIL 32'h0000_0258
`define EGRS_MOTOR_INC_PER_REV 32'h0002_0000
`define EGRS_LAG_LIMIT_REVS 32'h0000_0190

// ********************************
// timing
// ********************************
`define EGRS_CLK_PERIOD_NS 8
`define EGRS_TICK_NS 10000
`define EGRS_TICK_CYCLES (`EGRS_TICK_NS / `EGRS_CLK_PERIOD_NS)

`endif

// file: tb/egrs_gear_scaler_assertions.sv
// port assertions of the gear ratio scaler
`include "egrs_regs.vh"
module egrs_gear_scaler_assertions #(
    parameter TICK_CYCLES = `EGRS_TICK_CYCLES,
    parameter REF_W = 16
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // reference increments
    input wire refValid,
    input wire signed [REF_W-1:0] refInc,
    // parameter access
    input wire paramWrEn,
    input wire paramRdEn,
    input wire [15:0] paramAddr,
    input wire [31:0] paramWrData,
    input wire [31:0] paramRdData_q,
    input wire paramRdValid_q,
    // cyclic process data
    input wire pzdValid,
    input wire [15:0] pzdWord2,
    input wire [15:0] pzdWord3,
    input wire [15:0] pzdWord4,
    // position and status
    input wire signed [31:0] effPos_q,
    input wire signed [31:0] lag_q,
    input wire fault_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    reg limitOn_q;
    wire isNum = paramAddr == `EGRS_ADDR_NUM;
    wire isDen = paramAddr == `EGRS_ADDR_DENOM;
    wire mapped = isNum || isDen || paramAddr == `EGRS_ADDR_PRESET
        || paramAddr == `EGRS_ADDR_LIMIT_EN || paramAddr == `EGRS_ADDR_SPEED_CEIL
        || paramAddr == `EGRS_ADDR_ACCEL_CEIL || paramAddr == `EGRS_ADDR_LAG;
    // shadow of the limitation switch; refused values leave it alone
    always @(posedge clk) begin
        if (rst)
            limitOn_q <= 1'b0;
        else if (paramWrEn && paramAddr == `EGRS_ADDR_LIMIT_EN && paramWrData < 32'h0000_0002)
            limitOn_q <= paramWrData[0];
    end
    a_read_answer_pulse: assert property (disable iff (rst) paramRdEn |=> paramRdValid_q)
        else $error("read answer missing");
    a_no_stray_answer: assert property (disable iff (rst) !paramRdEn |=> !paramRdValid_q)
        else $error("read answer without request");
    a_reset_clears_outputs: assert property (rst |=> lag_q == 0 && effPos_q == 0 && !fault_q)
        else $error("outputs not cleared by reset");
    a_unmapped_reads_zero: assert property (disable iff (rst)
        paramRdEn && !mapped |=> paramRdData_q == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_num_write_readback: assert property (disable iff (rst)
        paramWrEn && !pzdValid && isNum ##1 !paramWrEn && !pzdValid ##1 paramRdEn && isNum
        |=> paramRdData_q == $past(paramWrData, 3))
        else $error("numerator readback differs");
    a_den_zero_refused: assert property (disable iff (rst)
        paramWrEn && isDen && paramWrData == 0 ##1 !paramWrEn ##1 paramRdEn && isDen
        |=> paramRdData_q != 32'h0000_0000)
        else $error("zero denominator taken");
    a_lag_settles_off: assert property (disable iff (rst)
        !limitOn_q && $past(!limitOn_q) && $past(!limitOn_q, 2) && !fault_q && lag_q != 0
        |=> lag_q == 0)
        else $error("lag persists without limitation");
    a_fault_sticky: assert property (disable iff (rst) fault_q |=> fault_q)
        else $error("fault dropped");
    a_fault_freezes_pos: assert property (disable iff (rst) fault_q |=> $stable(effPos_q))
        else $error("position moved under fault");
    a_lag_bound_fault: assert property (disable iff (rst)
        lag_q > 32'sh0320_0000 || lag_q < -32'sh0320_0000 |-> ##[0:2] fault_q)
        else $error("lag over bound without fault");
endmodule // egrs_gear_scaler_assertions

bind egrs_gear_scaler egrs_gear_scaler_assertions #(.TICK_CYCLES(TICK_CYCLES), .REF_W(REF_W))
    chk (.clk, .rst, .refValid, .refInc, .paramWrEn, .paramRdEn, .paramAddr, .paramWrData,
    .paramRdData_q, .paramRdValid_q, .pzdValid, .pzdWord2, .pzdWord3, .pzdWord4, .effPos_q,
    .lag_q, .fault_q);

// file: tb/egrs_ref_source.sv
// external controller model sending reference increments
module egrs_ref_source (
    // clock and reset
    input logic clk,
    input logic rst,
    // command
    input logic start,
    input logic signed [15:0] step,
    input logic [7:0] count,
    input logic slow,
    // increments toward the scaler
    output logic refValid,
    output logic signed [15:0] refInc,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left;
    logic pause;
    assign busy = start || left != 8'h00;
    always @(posedge clk) begin
        refValid <= 1'b0;
        // data outside a strobe is junk, never a stale copy
        refInc <= ~refInc;
        pause <= ~pause;
        // pause and data start unknown, so they need a defined value before slow mode
        if (rst) begin
            left <= 8'h00;
            refInc <= 16'h0000;
            pause <= 1'b0;
        end else if (start)
            left <= count;
        else if (left != 8'h00 && !(slow && pause)) begin
            refValid <= 1'b1;
            refInc <= step;
            left <= left - 8'h01;
        end
    end
endmodule // egrs_ref_source

// file: tb/tb_egrs_gear_scaler.sv
// self-checking bench of the gear ratio scaler
`include "egrs_regs.vh"
module tb_egrs_gear_scaler;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic pzdValid = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wrData = 32'h0000_0000;
    logic [15:0] w2 = 16'h0000;
    logic [15:0] w3 = 16'h0000;
    logic [15:0] w4 = 16'h0000;
    logic srcStart = 1'b0;
    logic signed [15:0] srcStep = 16'h0000;
    logic [7:0] srcCount = 8'h00;
    logic srcSlow = 1'b0;
    logic refValid;
    logic signed [15:0] refInc;
    logic [31:0] rdData;
    logic rdValid;
    logic signed [31:0] effPos;
    logic signed [31:0] lag;
    logic signed [31:0] expPos = 32'h0000_0000;
    int nMismatch = 0;
    int comparisons = 0;
    int nz;
    int maxStep;
    int step;
    logic signed [31:0] prevPos;
    logic fault;
    int revs [12] = '{0, 200, 400, 500, 1000, 2000, 4000, 5000, 10000, 4096, 8192, 16384};
    always #4 clk = ~clk;
    egrs_ref_source src (.clk(clk), .rst(rst), .start(srcStart), .step(srcStep),
        .count(srcCount), .slow(srcSlow), .refValid(refValid), .refInc(refInc), .busy());
    egrs_gear_scaler #(.TICK_CYCLES(4), .REF_W(16)) dut (.clk(clk), .rst(rst),
        .refValid(refValid), .refInc(refInc), .paramWrEn(wrEn), .paramRdEn(rdEn),
        .paramAddr(addr), .paramWrData(wrData), .paramRdData_q(rdData),
        .paramRdValid_q(rdValid), .pzdValid(pzdValid), .pzdWord2(w2), .pzdWord3(w3),
        .pzdWord4(w4), .effPos_q(effPos), .lag_q(lag), .fault_q(fault));
    task automatic endSim();
        $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
        if (nMismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        wrEn <= 1'b1;
        addr <= a;
        wrData <= d;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk);
        rdEn <= 1'b1;
        addr <= a;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        chk({31'h0000_0000, rdValid}, 32'h0000_0001);
        chk(rdData, exp);
    endtask
    task automatic pzd(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge clk);
        pzdValid <= 1'b1;
        w2 <= a;
        w3 <= b;
        w4 <= c;
        @(posedge clk);
        pzdValid <= 1'b0;
    endtask
    // odd counts go out with gaps, even counts back to back
    task automatic go(input logic signed [15:0] s, input logic [7:0] n, input logic signed [31:0] g);
        @(posedge clk);
        srcStart <= 1'b1;
        srcStep <= s;
        srcCount <= n;
        srcSlow <= n[0];
        @(posedge clk);
        srcStart <= 1'b0;
        expPos = expPos + g;
    endtask
    task automatic waitPos();
        for (int i = 0; i < 800 && effPos !== expPos; i++) begin
            @(posedge clk);
            #1;
        end
        chk(effPos, expPos);
        repeat (2) @(posedge clk);
        #1;
        chk(lag, 32'h0000_0000);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        chk(32'h0000_0000, 32'h0000_0001);
        endSim();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`EGRS_ADDR_NUM, 32'h0000_0001);
        rd(`EGRS_ADDR_DENOM, 32'h0000_0001);
        rd(`EGRS_ADDR_PRESET, 32'h0000_0000);
        rd(`EGRS_ADDR_LIMIT_EN, 32'h0000_0000);
        rd(16'h2600, 32'h0000_0000);
        for (int p = 1; p <= 11; p++) begin
            wr(`EGRS_ADDR_PRESET, 32'(p));
            go(16'(revs[p] / 4), 8'h04, 32'h0002_0000);
            waitPos();
        end
        wr(`EGRS_ADDR_PRESET, 32'h0000_000c);
        rd(`EGRS_ADDR_PRESET, 32'h0000_000b);
        wr(`EGRS_ADDR_PRESET, 32'h0000_0000);
        wr(`EGRS_ADDR_DENOM, 32'h0000_0003);
        go(16'h001e, 8'h01, 32'h0000_001e);
        waitPos();
        wr(`EGRS_ADDR_NUM, 32'h0000_0002);
        go(16'h001e, 8'h01, 32'h0000_0014);
        waitPos();
        go(16'h0001, 8'h03, 32'h0000_0002);
        waitPos();
        wr(`EGRS_ADDR_DENOM, 32'h0000_0000);
        rd(`EGRS_ADDR_DENOM, 32'h0000_0003);
        wr(`EGRS_ADDR_NUM, 32'hffff_ffff);
        rd(`EGRS_ADDR_NUM, 32'hffff_ffff);
        go(16'h001e, 8'h01, -32'sh0000_000a);
        waitPos();
        pzd(16'h0004, 16'h0000, 16'h0008);
        rd(`EGRS_ADDR_NUM, 32'h0000_0008);
        rd(`EGRS_ADDR_DENOM, 32'h0000_0004);
        go(16'h0032, 8'h01, 32'h0000_0064);
        waitPos();
        pzd(16'h0000, 16'hffff, 16'hfffe);
        go(16'h0028, 8'h01, -32'sh0000_0014);
        waitPos();
        wr(`EGRS_ADDR_DENOM, 32'h0000_0001);
        wr(`EGRS_ADDR_NUM, 32'h0000_0001);
        wr(`EGRS_ADDR_LIMIT_EN, 32'h0000_0002);
        rd(`EGRS_ADDR_LIMIT_EN, 32'h0000_0000);
        wr(`EGRS_ADDR_LIMIT_EN, 32'h0000_0001);
        rd(`EGRS_ADDR_LIMIT_EN, 32'h0000_0001);
        go(16'h4e20, 8'hc8, 32'h003d_0900);
        nz = 0;
        maxStep = 0;
        prevPos = effPos;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if (lag !== 32'h0000_0000)
                nz++;
            step = effPos - prevPos;
            if (step < 0)
                step = -step;
            if (step > maxStep)
                maxStep = step;
            prevPos = effPos;
        end
        chk({31'h0000_0000, nz > 100}, 32'h0000_0001);
        chk(32'(maxStep), `EGRS_RST_SPEED_CEIL);
        wr(`EGRS_ADDR_LIMIT_EN, 32'h0000_0000);
        waitPos();
        rd(`EGRS_ADDR_LAG, 32'h0000_0000);
        chk({31'h0000_0000, fault}, 32'h0000_0000);
        // one huge jump under limitation drives the lag past the fault bound
        wr(`EGRS_ADDR_LIMIT_EN, 32'h0000_0001);
        wr(`EGRS_ADDR_NUM, 32'h0400_0000);
        go(16'h0001, 8'h01, 32'h0000_0000);
        for (int i = 0; i < 200 && fault !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk({31'h0000_0000, fault}, 32'h0000_0001);
        prevPos = effPos;
        repeat (20) @(posedge clk);
        #1;
        chk(effPos, prevPos);
        chk({31'h0000_0000, fault}, 32'h0000_0001);
        // only a reset clears the fault
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({31'h0000_0000, fault}, 32'h0000_0000);
        chk(effPos, 32'h0000_0000);
        rd(`EGRS_ADDR_NUM, `EGRS_RST_NUM);
        rd(`EGRS_ADDR_LIMIT_EN, 32'h0000_0000);
        endSim();
    end
endmodule // tb_egrs_gear_scaler
